// File: rcbr_regs.sv
/*
 * Response curve breakpoint register bank: byte registers on the sensor
 * configuration port plus the per-pixel segment selection they steer.
 * Assumes the serial port front end gives one-cycle wr_en / rd_en strobes
 * with a byte address in the clk domain.
 */
module rcbr_regs #(
   parameter int unsigned PIX_W = 12
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [rcbr_pkg::ADDR_W-1:0] addr,
   input wire logic [rcbr_pkg::DATA_W-1:0] wr_data,
   output logic [rcbr_pkg::DATA_W-1:0] rd_data,
   output logic rd_hit,
   input wire logic pix_valid,
   input wire logic [PIX_W-1:0] pix_level,
   output logic sel_valid,
   output logic [1:0] sel_seg,
   output logic [rcbr_pkg::SLOPE_W-1:0] sel_slope,
   output logic [rcbr_pkg::SLOPE_W-1:0] seg0_slope_value,
   output logic [rcbr_pkg::SLOPE_W-1:0] seg1_slope_value,
   output logic [rcbr_pkg::LEVEL_W-1:0] knee1_level_a_value,
   output logic [rcbr_pkg::LEVEL_W-1:0] knee1_level_b_value,
   output logic knee1_copies_differ
);
   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (PIX_W < rcbr_pkg::LEVEL_W) begin : g_pix_w_check
      $error("PIX_W must be at least the level width");
   end
   if (rcbr_pkg::SLOPE_HI_W + rcbr_pkg::DATA_W != rcbr_pkg::SLOPE_W) begin : g_slope_w_check
      $error("Slope high and low bytes must fill the slope width");
   end

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   wire hit_s0h = addr == rcbr_pkg::SEG0_SLOPE_HIGH_OFS;
   wire hit_s0l = addr == rcbr_pkg::SEG0_SLOPE_LOW_OFS;
   wire hit_k1a = addr == rcbr_pkg::KNEE1_LEVEL_COPY_A_OFS;
   wire hit_s1h = addr == rcbr_pkg::SEG1_SLOPE_HIGH_OFS;
   wire hit_s1l = addr == rcbr_pkg::SEG1_SLOPE_LOW_OFS;
   wire hit_k1b = addr == rcbr_pkg::KNEE1_LEVEL_COPY_B_OFS;
   wire hit_k2 = addr == rcbr_pkg::KNEE2_LEVEL_OFS;
   wire hit_any = hit_s0h | hit_s0l | hit_k1a | hit_s1h | hit_s1l | hit_k1b | hit_k2;

   // ----------------------------------------------------------------
   // Write strobes per register
   // ----------------------------------------------------------------
   wire we_s0h = wr_en && hit_s0h;
   wire we_s0l = wr_en && hit_s0l;
   wire we_k1a = wr_en && hit_k1a;
   wire we_s1h = wr_en && hit_s1h;
   wire we_s1l = wr_en && hit_s1l;
   wire we_k1b = wr_en && hit_k1b;
   wire we_k2 = wr_en && hit_k2;

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [rcbr_pkg::SLOPE_HI_W-1:0] seg0_slope_high_q;
   logic [7:0] seg0_slope_low_q;
   logic [7:0] knee1_level_copy_a_q;
   logic [rcbr_pkg::SLOPE_HI_W-1:0] seg1_slope_high_q;
   logic [7:0] seg1_slope_low_q;
   logic [7:0] knee1_level_copy_b_q;
   logic [7:0] knee2_level_q;
   logic [7:0] rd_data_q;
   logic rd_hit_q;
   logic knee1_differ_q;

   wire [rcbr_pkg::SLOPE_HI_W-1:0] wr_hi =
      wr_data[rcbr_pkg::SLOPE_HI_MSB:rcbr_pkg::SLOPE_HI_LSB];

   // One short block per register; reserved high bits are never stored
   always_ff @(posedge clk) begin
      if (srst) begin
         seg0_slope_high_q <= rcbr_pkg::REG_RESET[rcbr_pkg::SLOPE_HI_W-1:0];
      end else if (we_s0h) begin
         seg0_slope_high_q <= wr_hi;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         seg0_slope_low_q <= rcbr_pkg::REG_RESET;
      end else if (we_s0l) begin
         seg0_slope_low_q <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         knee1_level_copy_a_q <= rcbr_pkg::REG_RESET;
      end else if (we_k1a) begin
         knee1_level_copy_a_q <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         seg1_slope_high_q <= rcbr_pkg::REG_RESET[rcbr_pkg::SLOPE_HI_W-1:0];
      end else if (we_s1h) begin
         seg1_slope_high_q <= wr_hi;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         seg1_slope_low_q <= rcbr_pkg::REG_RESET;
      end else if (we_s1l) begin
         seg1_slope_low_q <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         knee1_level_copy_b_q <= rcbr_pkg::REG_RESET;
      end else if (we_k1b) begin
         knee1_level_copy_b_q <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         knee2_level_q <= rcbr_pkg::REG_RESET;
      end else if (we_k2) begin
         knee2_level_q <= wr_data;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Reserved high bits read as zero
   wire [7:0] rd_s0h = {2'h0, seg0_slope_high_q};
   wire [7:0] rd_s1h = {2'h0, seg1_slope_high_q};
   wire [7:0] rd_mux =
      hit_s0h ? rd_s0h :
      hit_s0l ? seg0_slope_low_q :
      hit_k1a ? knee1_level_copy_a_q :
      hit_s1h ? rd_s1h :
      hit_s1l ? seg1_slope_low_q :
      hit_k1b ? knee1_level_copy_b_q :
      hit_k2 ? knee2_level_q : rcbr_pkg::UNMAPPED_READ;

   // Read data holds until the next read strobe
   always_ff @(posedge clk) begin
      if (srst) begin
         rd_data_q <= rcbr_pkg::REG_RESET;
      end else if (rd_en) begin
         rd_data_q <= rd_mux;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rd_hit_q <= 1'b0;
      end else if (rd_en) begin
         rd_hit_q <= hit_any;
      end
   end

   assign rd_data = rd_data_q;
   assign rd_hit = rd_hit_q;

   // ----------------------------------------------------------------
   // Settings out to the datapath
   // ----------------------------------------------------------------
   assign seg0_slope_value = {seg0_slope_high_q, seg0_slope_low_q};
   assign seg1_slope_value = {seg1_slope_high_q, seg1_slope_low_q};
   assign knee1_level_a_value = knee1_level_copy_a_q;
   assign knee1_level_b_value = knee1_level_copy_b_q;

   // ----------------------------------------------------------------
   // Level copy mismatch flag
   // ----------------------------------------------------------------
   // Flags a host that broke the matching-copies convention
   wire knee1_differ_d = knee1_level_copy_a_q != knee1_level_copy_b_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         knee1_differ_q <= 1'b0;
      end else begin
         knee1_differ_q <= knee1_differ_d;
      end
   end
   assign knee1_copies_differ = knee1_differ_q;

   wire seg0_en = |seg0_slope_value;
   wire seg1_en = |seg1_slope_value;

   // ----------------------------------------------------------------
   // Segment selection
   // ----------------------------------------------------------------
   rcbr_seg_select #(
      .PIX_W(PIX_W)
   ) u_sel (
      .clk(clk),
      .srst(srst),
      .pix_valid(pix_valid),
      .pix_level(pix_level),
      .knee1_level(knee1_level_copy_a_q),
      .knee2_level(knee2_level_q),
      .seg0_en(seg0_en),
      .seg1_en(seg1_en),
      .seg0_slope(seg0_slope_value),
      .seg1_slope(seg1_slope_value),
      .sel_valid(sel_valid),
      .sel_seg(sel_seg),
      .sel_slope(sel_slope)
   );
endmodule : rcbr_regs

// File: rcbr_pkg.sv
/*
 * Package for the response curve breakpoint register bank: byte offsets on
 * the configuration port, field layouts, reset values and widths.
 * Assumes the configuration port presents byte-wide addressed accesses.
 */
package rcbr_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned SLOPE_W = 14;
   localparam int unsigned SLOPE_HI_W = 6;
   localparam int unsigned LEVEL_W = 8;

   localparam logic [7:0] SEG0_SLOPE_HIGH_OFS = 8'h1d;
   localparam logic [7:0] SEG0_SLOPE_LOW_OFS = 8'h1e;
   localparam logic [7:0] KNEE1_LEVEL_COPY_A_OFS = 8'h1f;
   localparam logic [7:0] SEG1_SLOPE_HIGH_OFS = 8'h20;
   localparam logic [7:0] SEG1_SLOPE_LOW_OFS = 8'h21;
   localparam logic [7:0] KNEE1_LEVEL_COPY_B_OFS = 8'h24;
   localparam logic [7:0] KNEE2_LEVEL_OFS = 8'h25;

   localparam int unsigned SLOPE_HI_LSB = 0;
   localparam int unsigned SLOPE_HI_MSB = 5;

   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Segment selection codes
   localparam logic [1:0] SEG_LINEAR = 2'h0;
   localparam logic [1:0] SEG_ZERO = 2'h1;
   localparam logic [1:0] SEG_ONE = 2'h2;
endpackage : rcbr_pkg

// File: rcbr_seg_select.sv
/*
 * Per-pixel segment selector for the response curve.
 * Assumes pixel level and settings are in the clk domain.
 */
module rcbr_seg_select #(
   parameter int unsigned PIX_W = 12
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic pix_valid,
   input wire logic [PIX_W-1:0] pix_level,
   input wire logic [rcbr_pkg::LEVEL_W-1:0] knee1_level,
   input wire logic [rcbr_pkg::LEVEL_W-1:0] knee2_level,
   input wire logic seg0_en,
   input wire logic seg1_en,
   input wire logic [rcbr_pkg::SLOPE_W-1:0] seg0_slope,
   input wire logic [rcbr_pkg::SLOPE_W-1:0] seg1_slope,
   output logic sel_valid,
   output logic [1:0] sel_seg,
   output logic [rcbr_pkg::SLOPE_W-1:0] sel_slope
);
   if (PIX_W < rcbr_pkg::LEVEL_W) begin : g_pix_w_check
      $error("PIX_W must be at least the level width");
   end

   // Level compared against the top bits of the pixel
   wire [rcbr_pkg::LEVEL_W-1:0] pix_top = pix_level[PIX_W-1 -: rcbr_pkg::LEVEL_W];
   wire below_knee1 = pix_top < knee1_level;
   wire below_knee2 = pix_top < knee2_level;
   wire use_zero = below_knee1 && seg0_en;
   wire use_one = !below_knee1 && below_knee2 && seg1_en;
   wire [1:0] seg_d = use_zero ? rcbr_pkg::SEG_ZERO :
                      use_one ? rcbr_pkg::SEG_ONE : rcbr_pkg::SEG_LINEAR;
   wire [rcbr_pkg::SLOPE_W-1:0] slope_d = use_zero ? seg0_slope :
                                          use_one ? seg1_slope : '0;

   logic sel_valid_q;
   logic [1:0] sel_seg_q;
   logic [rcbr_pkg::SLOPE_W-1:0] sel_slope_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         sel_valid_q <= 1'b0;
         sel_seg_q <= rcbr_pkg::SEG_LINEAR;
         sel_slope_q <= '0;
      end else begin
         sel_valid_q <= pix_valid;
         sel_seg_q <= seg_d;
         sel_slope_q <= slope_d;
      end
   end

   assign sel_valid = sel_valid_q;
   assign sel_seg = sel_seg_q;
   assign sel_slope = sel_slope_q;
endmodule : rcbr_seg_select

// File: rcbr_host.sv
/* Host model on the configuration port.
   Assumes strobes are sampled on rising clk and driven at falling edges. */
module rcbr_host (
   input wire logic clk,
   input wire logic [7:0] rd_data,
   output logic wr_en,
   output logic rd_en,
   output logic [7:0] addr,
   output logic [7:0] wr_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {wr_en, rd_en, addr, wr_data} = 18'h0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      {wr_en, addr, wr_data} = {1'b1, a, d};
      @(negedge clk);
      wr_en = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      {rd_en, addr} = {1'b1, a};
      @(negedge clk);
      rd_en = 1'b0;
      d = rd_data;
   endtask : rd
   // Both level copies always get one value
   task automatic knee1(input logic [7:0] v);
      wr(8'h1f, v);
      wr(8'h24, v);
   endtask : knee1
endmodule : rcbr_host

// File: rcbr_regs_sva.sv
/* Checker for rcbr_regs.
   Assumes it is bound to the register bank ports. */
module rcbr_regs_sva #(parameter int unsigned PIX_W = 12) (
   input wire logic clk,
   input wire logic srst,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic pix_valid,
   input wire logic [PIX_W-1:0] pix_level,
   input wire logic [1:0] sel_seg,
   input wire logic [13:0] sel_slope,
   input wire logic [13:0] seg0_slope_value,
   input wire logic [13:0] seg1_slope_value,
   input wire logic [7:0] knee1_level_a_value
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   wire [7:0] top = pix_level[PIX_W-1 -: 8];
   wire [13:0] s0 = seg0_slope_value;
   wire [13:0] s1 = seg1_slope_value;
   property p_s0; wr_en && addr == 8'h1d |=> s0[13:8] == $past(wr_data[5:0]); endproperty
   a_s0: assert property (p_s0) else $error("seg0 high lost");
   property p_nobp; sel_seg == 2'h1 |-> $past(s0) != 14'h0; endproperty
   a_nobp: assert property (p_nobp) else $error("zero slope used");
   property p_lev; wr_en && addr == 8'h1f |=> knee1_level_a_value == $past(wr_data); endproperty
   a_lev: assert property (p_lev) else $error("level lost");
   property p_s1; wr_en && addr == 8'h21 |=> s1[7:0] == $past(wr_data); endproperty
   a_s1: assert property (p_s1) else $error("seg1 low lost");
   property p_rd; rd_en && addr == 8'h20 |=> rd_data == {2'h0, $past(s1[13:8])}; endproperty
   a_rd: assert property (p_rd) else $error("bad read");
   property p_rst; $fell(srst) |-> s0 == 14'h0 && s1 == 14'h0; endproperty
   a_rst: assert property (p_rst) else $error("not cleared");
   property p_sel; pix_valid && top < knee1_level_a_value && s0 != 14'h0
      |=> sel_seg == 2'h1 && sel_slope == $past(s0); endproperty
   a_sel: assert property (p_sel) else $error("bad segment");
   cover property (sel_seg == 2'h1);
   cover property (sel_seg == 2'h2);
   cover property (rd_en && addr == 8'h24);
endmodule : rcbr_regs_sva
bind rcbr_regs rcbr_regs_sva #(.PIX_W(PIX_W)) i_sva (.clk(clk), .srst(srst), .wr_en(wr_en),
   .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .pix_valid(pix_valid),
   .pix_level(pix_level), .sel_seg(sel_seg), .sel_slope(sel_slope),
   .seg0_slope_value(seg0_slope_value), .seg1_slope_value(seg1_slope_value),
   .knee1_level_a_value(knee1_level_a_value));

// File: test_response_curve_breakpoint_regs.sv
/* Self-checking bench for the breakpoint register bank.
   Assumes rcbr_host drives the configuration port. */
module test_response_curve_breakpoint_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, srst = 1'b1, pix_valid = 1'b0, wr_en, rd_en, hit, differ, sel_v;
   logic [11:0] pix_level = 12'h0;
   logic [7:0] addr, wr_data, rd_data, rd_v, lev_a, lev_b;
   logic [7:0] regs [7] = '{8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h24, 8'h25};
   logic [1:0] sel_seg;
   logic [13:0] sel_slope, s0, s1;
   int failures = 0, checked = 0;
   initial forever #5 clk = ~clk;
   rcbr_host i_host (.clk(clk), .rd_data(rd_data), .wr_en(wr_en), .rd_en(rd_en),
      .addr(addr), .wr_data(wr_data));
   rcbr_regs #(.PIX_W(12)) i_dut (.clk(clk), .srst(srst), .wr_en(wr_en), .rd_en(rd_en),
      .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_hit(hit), .pix_valid(pix_valid),
      .pix_level(pix_level), .sel_valid(sel_v), .sel_seg(sel_seg), .sel_slope(sel_slope),
      .seg0_slope_value(s0), .seg1_slope_value(s1), .knee1_level_a_value(lev_a),
      .knee1_level_b_value(lev_b), .knee1_copies_differ(differ));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      i_host.rd(a, rd_v);
      chk({8'h0, rd_v}, {8'h0, exp});
   endtask : rchk
   task automatic pix(input logic [7:0] top, input logic [1:0] seg, input logic [13:0] sl);
      @(negedge clk);
      {pix_valid, pix_level} = {1'b1, top, 4'h0};
      @(negedge clk);
      pix_valid = 1'b0;
      chk({15'h0, sel_v}, 16'h0001);
      chk({14'h0, sel_seg}, {14'h0, seg});
      chk({2'h0, sel_slope}, {2'h0, sl});
   endtask : pix
   task automatic results;
      $display("failures=%0d checked=%0d", failures, checked);
      if (failures == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   initial begin
      repeat (12) @(posedge clk);
      @(negedge clk) srst = 1'b0;
      foreach (regs[i]) rchk(regs[i], 8'h00);
      chk({15'h0, hit}, 16'h0001);
      foreach (regs[i]) i_host.wr(regs[i], 8'hff);
      foreach (regs[i]) rchk(regs[i], regs[i] inside {8'h1d, 8'h20} ? 8'h3f : 8'hff);
      chk({2'h0, s0}, 16'h3fff);
      chk({2'h0, s1}, 16'h3fff);
      i_host.wr(8'h22, 8'h5a);
      rchk(8'h22, 8'h00);
      chk({15'h0, hit}, 16'h0);
      i_host.wr(8'h1d, 8'h00);
      i_host.wr(8'h1e, 8'h10);
      i_host.knee1(8'h80);
      chk({8'h0, lev_a}, 16'h0080);
      chk({8'h0, lev_b}, 16'h0080);
      i_host.wr(8'h20, 8'h02);
      i_host.wr(8'h21, 8'h00);
      i_host.wr(8'h25, 8'hc0);
      chk({15'h0, differ}, 16'h0);
      pix(8'h7f, 2'h1, 14'h0010);
      pix(8'h80, 2'h2, 14'h0200);
      pix(8'hc0, 2'h0, 14'h0000);
      i_host.wr(8'h1e, 8'h00);
      pix(8'h10, 2'h0, 14'h0000);
      @(negedge clk) srst = 1'b1;
      @(negedge clk) srst = 1'b0;
      rchk(8'h1f, 8'h00);
      results();
   end
endmodule : test_response_curve_breakpoint_regs
